// *** hw/rmuv_top.sv ***
// reset manager with undervoltage flag, mask and summary interrupt logic
// Behaviour
// (R1) fourteen undervoltage flags feed one summary
// (R2) regulator flags bits 9:0, rising-edge set
// (R3) converter flags bits 3:0, rising-edge set
// (R4) flag clears only on written one
// (R5) set mask bit blocks flag from summary
// (R6) flags latch regardless of mask
// (R7) all masks are one after reset
// (R8) system reset causes: pin low, OFF
// (R9) always-on supply low enters BACKUP
// (R10) system reset keeps register map
// (R11) device reset: pin low, OFF, defaults
// (R12) device reset restarts to ON
// (R13) any write to 0000h: software reset; code acts on it only in start-up or ON
// (R14) software reset honours map-keep, restarts; code restarts only when issued from ON
// (R15) below POR: NO POWER, map lost
// (R16) main supply low needs OFF action
// (R17) main supply shutdown always resets system
// (R18) start-up failure is system reset
// (R19) chip-on write zero powers down
// (R20) watchdog resets only if selected
// (R21) converter undervoltage resets only if selected
// (R22) external low on pin: device reset
// (R23) at most six device, software resets
// (R24) pin low unless ON after start-up
// (R25) map-keep zero clears, one keeps, default one
// (R26) summary high while any unmasked flag
`timescale 1ns/1ps
`include "rmuv_consts.svh"

module rmuv_top (
  input wire logic clk, // 200 MHz clock
  input wire logic arst_n, // async reset, low
  input wire rmuv_pkg::rmuv_bus_req_t bus_i, // register request
  output logic [15:0] rdata_o, // read data, next cycle
  input wire rmuv_pkg::rmuv_uv_t uv_i, // undervoltage levels
  input wire rmuv_pkg::rmuv_cond_t cond_i, // monitors, watchdog
  input wire logic rst_pin_i, // reset pin level
  output logic rst_pin_o, // reset pin drive value
  output logic rst_pin_oe, // reset pin drive enable
  output logic undervoltage_summary_irq, // summary, high
  output rmuv_pkg::rmuv_state_t power_state_o, // power state
  output logic startup_req_o // run start-up sequence
);

  // value after reset and after power-on loss
  localparam rmuv_pkg::rmuv_regs_t RST_C = '{
    st: rmuv_pkg::ST_NOPWR,
    flg: '0,
    msk: '{ldo: `RMUV_LDO_MSK_RST, dc: `RMUV_DC_MSK_RST},
    prev: '0,
    sel: '0,
    chip_on: 1'b0,
    low_act: `RMUV_LOWACT_RST,
    wd_sel: `RMUV_WDSEL_RST,
    keep: `RMUV_KEEP_RST,
    dev_cnt: 3'h0,
    sw_cnt: 3'h0,
    restart: 1'b0,
    armed: 1'b0,
    pin_oe: 1'b1,
    start_req: 1'b0,
    irq: 1'b0,
    rdata: 16'h0000
  };

  rmuv_pkg::rmuv_regs_t q; // registered state
  rmuv_pkg::rmuv_regs_t d; // next state
  logic [13:0] rise_v; // rising edges of undervoltage
  logic [13:0] clr_v; // written-one clears
  logic active; // start-up or ON
  logic soft_req; // write to soft reset trigger
  logic off_req; // chip-on written zero
  logic sys_rst; // any system reset cause
  logic dev_rst; // any device reset cause
  logic ext_rst; // external pull on reset pin
  logic uv_dev; // selected undervoltage event

  // return map registers to defaults; counters and state stay
  function automatic rmuv_pkg::rmuv_regs_t clr_map(
    input rmuv_pkg::rmuv_regs_t r
  );
    rmuv_pkg::rmuv_regs_t t;
    t = r;
    t.flg = '0;
    t.msk = RST_C.msk;
    t.sel = '0;
    t.chip_on = 1'b0;
    t.low_act = RST_C.low_act;
    t.wd_sel = RST_C.wd_sel;
    t.keep = RST_C.keep;
    return t;
  endfunction

  // next-state logic for flags, registers and the power state
  always_comb begin
    d = q;
    // edge detect on the undervoltage levels
    rise_v = uv_i & ~q.prev;
    d.prev = uv_i;
    // write-one-to-clear masks per status register
    clr_v = '0;
    if (bus_i.wr && bus_i.addr == `RMUV_A_LDO_FLG) begin
      clr_v[13:4] = bus_i.wdata[9:0]; // R4
    end
    if (bus_i.wr && bus_i.addr == `RMUV_A_DC_FLG) begin
      clr_v[3:0] = bus_i.wdata[3:0]; // R4
    end
    // set wins over clear; masks play no part here
    d.flg = (q.flg & ~clr_v) | rise_v; // R2 R3 R6
    // plain read-write control registers
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        `RMUV_A_LDO_MSK: begin
          d.msk.ldo = bus_i.wdata[9:0];
        end
        `RMUV_A_DC_MSK: begin
          d.msk.dc = bus_i.wdata[3:0];
        end
        `RMUV_A_LDO_SEL: begin
          d.sel.ldo = bus_i.wdata[9:0];
        end
        `RMUV_A_DC_SEL: begin
          d.sel.dc = bus_i.wdata[3:0];
        end
        `RMUV_A_RSTCTL: begin
          d.keep = bus_i.wdata[`RMUV_KEEP_BIT]; // R25
        end
        `RMUV_A_PWRCTL: begin
          d.chip_on = bus_i.wdata[`RMUV_CHIP_ON_BIT];
          d.low_act = bus_i.wdata[`RMUV_LOWACT_BIT];
          d.wd_sel = bus_i.wdata[`RMUV_WDSEL_BIT];
        end
        default: begin
          // other addresses hold no writable state
        end
      endcase
    end
    // reset causes
    active = (q.st == rmuv_pkg::ST_START) || (q.st == rmuv_pkg::ST_ON);
    soft_req = bus_i.wr && bus_i.addr == `RMUV_A_SWRST; // R13
    off_req = bus_i.wr && bus_i.addr == `RMUV_A_PWRCTL
      && !bus_i.wdata[`RMUV_CHIP_ON_BIT]; // R19
    sys_rst = cond_i.seq_fail // R18
      || cond_i.over_temp // R8
      || (cond_i.main_low && q.low_act) // R16
      || cond_i.main_shutdown // R17
      || off_req; // R19
    uv_dev = |(rise_v & q.sel); // R21
    ext_rst = q.armed && !rst_pin_i; // R22
    dev_rst = (cond_i.wdog_expired && q.wd_sel) // R20
      || ext_rst || uv_dev; // R11
    // power state machine, highest priority first
    if (cond_i.por_low) begin
      // all contents lost, no automatic recovery
      d = RST_C; // R15
      d.prev = uv_i;
    end else if (cond_i.aon_low && q.st != rmuv_pkg::ST_NOPWR) begin
      // always-on supply low goes to backup, map kept
      d.st = rmuv_pkg::ST_BACKUP; // R9
      d.restart = 1'b0;
    end else begin
      unique case (q.st)
        rmuv_pkg::ST_NOPWR: begin
          // supply back: wait in OFF for an on event
          d.st = rmuv_pkg::ST_OFF;
        end
        rmuv_pkg::ST_BACKUP: begin
          // always-on supply back
          d.st = rmuv_pkg::ST_OFF;
        end
        rmuv_pkg::ST_OFF: begin
          if (q.restart) begin
            // automatic recovery after a reset
            d.st = rmuv_pkg::ST_START; // R12 R14
            d.restart = 1'b0;
          end else if (cond_i.on_event) begin
            // a new valid on event restores the retry budget
            d.st = rmuv_pkg::ST_START;
            d.dev_cnt = 3'h0;
            d.sw_cnt = 3'h0;
          end
        end
        rmuv_pkg::ST_START, rmuv_pkg::ST_ON: begin
          if (sys_rst) begin
            // system reset: OFF, no restart, map kept
            d.st = rmuv_pkg::ST_OFF; // R8 R10
            d.restart = 1'b0;
          end else if (dev_rst) begin
            // device reset: defaults, OFF, restart in budget
            d = clr_map(d); // R11
            // an undervoltage edge in this very cycle still latches
            d.flg = rmuv_pkg::rmuv_uv_t'(rise_v); // R2 R3
            d.st = rmuv_pkg::ST_OFF;
            d.restart = q.dev_cnt < `RMUV_RETRY_MAX; // R23
            if (q.dev_cnt < `RMUV_RETRY_MAX) begin
              d.dev_cnt = q.dev_cnt + 3'h1;
            end
          end else if (soft_req) begin
            // software reset: map per keep field
            if (!q.keep) begin
              d = clr_map(d); // R25
              d.flg = rmuv_pkg::rmuv_uv_t'(rise_v); // R2 R3
            end
            d.st = rmuv_pkg::ST_OFF; // R13
            // restart only when issued from ON
            d.restart = q.st == rmuv_pkg::ST_ON
              && q.sw_cnt < `RMUV_RETRY_MAX; // R14 R23
            if (q.sw_cnt < `RMUV_RETRY_MAX) begin
              d.sw_cnt = q.sw_cnt + 3'h1;
            end
          end else if (q.st == rmuv_pkg::ST_START && cond_i.startup_done) begin
            // start-up complete
            d.st = rmuv_pkg::ST_ON;
            d.chip_on = 1'b1;
          end
        end
        default: begin
          // illegal code: fall back to OFF
          d.st = rmuv_pkg::ST_OFF;
        end
      endcase
    end
    // pin low everywhere but ON
    d.pin_oe = d.st != rmuv_pkg::ST_ON; // R24
    // pin sensing armed once the pin has been released a cycle
    d.armed = q.st == rmuv_pkg::ST_ON && d.st == rmuv_pkg::ST_ON; // R22
    d.start_req = d.st == rmuv_pkg::ST_START;
    // summary interrupt from unmasked flags
    d.irq = |(d.flg & ~d.msk); // R1 R5 R26
    // read data, one cycle after the strobe
    d.rdata = 16'h0000;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `RMUV_A_LDO_FLG: begin
          d.rdata[9:0] = q.flg.ldo;
        end
        `RMUV_A_DC_FLG: begin
          d.rdata[3:0] = q.flg.dc;
        end
        `RMUV_A_LDO_MSK: begin
          d.rdata[9:0] = q.msk.ldo;
        end
        `RMUV_A_DC_MSK: begin
          d.rdata[3:0] = q.msk.dc;
        end
        `RMUV_A_LDO_SEL: begin
          d.rdata[9:0] = q.sel.ldo;
        end
        `RMUV_A_DC_SEL: begin
          d.rdata[3:0] = q.sel.dc;
        end
        `RMUV_A_RSTCTL: begin
          d.rdata[`RMUV_KEEP_BIT] = q.keep;
        end
        `RMUV_A_PWRCTL: begin
          d.rdata[`RMUV_CHIP_ON_BIT] = q.chip_on;
          d.rdata[`RMUV_LOWACT_BIT] = q.low_act;
          d.rdata[`RMUV_WDSEL_BIT] = q.wd_sel;
        end
        `RMUV_A_STATUS: begin
          d.rdata[`RMUV_ST_LSB +: 3] = q.st;
          d.rdata[`RMUV_DEVCNT_LSB +: 3] = q.dev_cnt;
          d.rdata[`RMUV_SWCNT_LSB +: 3] = q.sw_cnt;
        end
        default: begin
          // unmapped and write-only addresses read zero
          d.rdata = 16'h0000;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST_C; // R7
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register, pin drive value tied low
  assign rdata_o = q.rdata;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = q.pin_oe;
  assign undervoltage_summary_irq = q.irq;
  assign power_state_o = q.st;
  assign startup_req_o = q.start_req;

  // checks on the flag, mask and reset behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // a rising regulator edge is latched in every state but power loss
  flag_set_a: assert property ( // R2
    !cond_i.por_low
    |=> (q.flg.ldo & $past(rise_v[13:4])) == $past(rise_v[13:4])
  ) else $error("regulator undervoltage edge not latched");

  // a rising converter edge is latched in every state but power loss
  conv_set_a: assert property ( // R3
    !cond_i.por_low
    |=> (q.flg.dc & $past(rise_v[3:0])) == $past(rise_v[3:0])
  ) else $error("converter undervoltage edge not latched");

  // writing zeros never clears a flag
  zero_write_a: assert property ( // R4
    bus_i.wr && bus_i.addr == `RMUV_A_LDO_FLG && bus_i.wdata == 16'h0000
      && !cond_i.por_low && !dev_rst
    |=> (q.flg.ldo & $past(q.flg.ldo)) == $past(q.flg.ldo)
  ) else $error("flag cleared by a zero write");

  // an unmasked edge raises the summary on the next edge
  unmasked_raise_a: assert property ( // R5
    |(rise_v & ~q.msk) && !bus_i.wr && !cond_i.por_low && !dev_rst
    |=> undervoltage_summary_irq
  ) else $error("unmasked undervoltage edge did not raise summary");

  // an external pull while armed is a device reset
  ext_reset_a: assert property ( // R22
    q.armed && !rst_pin_i && !cond_i.por_low && !cond_i.aon_low && !sys_rst
    |=> q.st == rmuv_pkg::ST_OFF && q.pin_oe && q.msk == 14'h3FFF
  ) else $error("external reset pull not honoured");

  // summary follows unmasked flags
  summary_irq_a: assert property ( // R26
    undervoltage_summary_irq == |(q.flg & ~q.msk)
  ) else $error("summary interrupt disagrees with flags");

  // masks all set when reset is released
  mask_reset_a: assert property ( // R7
    @(posedge clk) $rose(arst_n) |-> q.msk == 14'h3FFF
  ) else $error("masks not set after reset");

  // overtemperature while active: OFF, pin low, no restart, masks kept
  sys_reset_a: assert property ( // R8
    active && cond_i.over_temp && !cond_i.por_low && !cond_i.aon_low
      && !bus_i.wr
    |=> q.st == rmuv_pkg::ST_OFF && q.pin_oe && !q.restart
      && q.msk == $past(q.msk) ##1 q.st == rmuv_pkg::ST_OFF
  ) else $error("system reset response wrong");

  // always-on supply low enters backup
  backup_entry_a: assert property ( // R9
    cond_i.aon_low && !cond_i.por_low && q.st != rmuv_pkg::ST_NOPWR
    |=> q.st == rmuv_pkg::ST_BACKUP && rst_pin_oe
  ) else $error("backup state not entered");

  // pending restart starts up on the next edge
  auto_restart_a: assert property ( // R12
    q.st == rmuv_pkg::ST_OFF && q.restart && !cond_i.por_low
      && !cond_i.aon_low
    |=> q.st == rmuv_pkg::ST_START && startup_req_o
  ) else $error("automatic restart missing");

  // pin driven low whenever not ON
  pin_low_a: assert property ( // R24
    q.st != rmuv_pkg::ST_ON |-> rst_pin_oe && !rst_pin_o
  ) else $error("reset pin released outside ON");

  // retry counters never exceed the budget
  retry_cap_a: assert property ( // R23
    q.dev_cnt <= `RMUV_RETRY_MAX && q.sw_cnt <= `RMUV_RETRY_MAX
  ) else $error("retry counter above limit");

  // power-on loss: NO POWER, flags cleared, masks back to ones
  por_loss_a: assert property ( // R15
    cond_i.por_low |=> q.st == rmuv_pkg::ST_NOPWR && q.flg == '0
      && q.msk == 14'h3FFF
  ) else $error("power-on loss handling wrong");

endmodule // rmuv_top

// *** hw/rmuv_consts.svh ***
// register offsets, field positions, reset values and limits of the reset manager
`ifndef RMUV_CONSTS_SVH
`define RMUV_CONSTS_SVH
`define RMUV_A_SWRST 16'h0000
`define RMUV_A_RSTCTL 16'h4006
`define RMUV_A_LDO_FLG 16'h4013
`define RMUV_A_DC_FLG 16'h4014
`define RMUV_A_LDO_MSK 16'h401B
`define RMUV_A_DC_MSK 16'h401C
`define RMUV_A_PWRCTL 16'h4020
`define RMUV_A_LDO_SEL 16'h4021
`define RMUV_A_DC_SEL 16'h4022
`define RMUV_A_STATUS 16'h4023
`define RMUV_KEEP_BIT 10
`define RMUV_CHIP_ON_BIT 0
`define RMUV_LOWACT_BIT 1
`define RMUV_WDSEL_BIT 2
`define RMUV_ST_LSB 0
`define RMUV_DEVCNT_LSB 4
`define RMUV_SWCNT_LSB 8
`define RMUV_LDO_MSK_RST 10'h3FF
`define RMUV_DC_MSK_RST 4'hF
`define RMUV_KEEP_RST 1'b1
`define RMUV_LOWACT_RST 1'b0
`define RMUV_WDSEL_RST 1'b0
`define RMUV_RETRY_MAX 3'h6
`endif

// *** hw/rmuv_pkg.sv ***
// types shared by the reset manager and undervoltage flag logic
package rmuv_pkg;
  // power states
  typedef enum logic [2:0] {
    ST_NOPWR = 3'h0,
    ST_BACKUP = 3'h1,
    ST_OFF = 3'h2,
    ST_START = 3'h3,
    ST_ON = 3'h4
  } rmuv_state_t;
  // register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rmuv_bus_req_t;
  // one bit per regulator and per converter
  typedef struct packed {
    logic [9:0] ldo;
    logic [3:0] dc;
  } rmuv_uv_t;
  // supply monitors, watchdog and sequencer inputs
  typedef struct packed {
    logic por_low;
    logic aon_low;
    logic seq_fail;
    logic over_temp;
    logic main_low;
    logic main_shutdown;
    logic wdog_expired;
    logic on_event;
    logic startup_done;
  } rmuv_cond_t;
  // whole state of the block
  typedef struct packed {
    rmuv_state_t st;
    rmuv_uv_t flg;
    rmuv_uv_t msk;
    rmuv_uv_t prev;
    rmuv_uv_t sel;
    logic chip_on;
    logic low_act;
    logic wd_sel;
    logic keep;
    logic [2:0] dev_cnt;
    logic [2:0] sw_cnt;
    logic restart;
    logic armed;
    logic pin_oe;
    logic start_req;
    logic irq;
    logic [15:0] rdata;
  } rmuv_regs_t;
endpackage

// *** verif/rmuv_host.sv ***
// host-side model of the open-drain reset pin and its pull-up
`timescale 1ns/1ps
module rmuv_host (
  input wire logic dev_oe, // device drives pin
  input wire logic dev_o, // device drive value
  input wire logic pull, // host pulls pin low
  output logic pin_lvl // resolved pin level
);
  // pull-up holds the pin high unless a party drives it low
  assign pin_lvl = !((dev_oe && !dev_o) || pull);
endmodule // rmuv_host

// *** verif/testbench.sv ***
// self-checking bench for the reset manager and undervoltage flags
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0; // 200 MHz clock
  logic arst_n = 1'b0; // async reset, low
  rmuv_pkg::rmuv_bus_req_t bus = '0; // register request
  rmuv_pkg::rmuv_uv_t uv = '0; // undervoltage levels
  rmuv_pkg::rmuv_cond_t cnd = '0; // monitor inputs
  logic pull = 1'b0; // host pulls pin low
  logic pin_lvl; // resolved pin level
  logic [15:0] rdata; // read data
  logic pin_o; // pin drive value
  logic pin_oe; // pin drive enable
  logic irq; // summary interrupt
  rmuv_pkg::rmuv_state_t st; // power state
  logic sreq; // start-up request
  int mismatches = 0; // failed compares
  int checked = 0; // compares made
  // clock, 5 ns period
  always #2.5 clk = ~clk;
  rmuv_top dut (.clk(clk), .arst_n(arst_n), .bus_i(bus), .rdata_o(rdata), .uv_i(uv),
    .cond_i(cnd), .rst_pin_i(pin_lvl), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe),
    .undervoltage_summary_irq(irq), .power_state_o(st), .startup_req_o(sreq));
  rmuv_host host (.dev_oe(pin_oe), .dev_o(pin_o), .pull(pull), .pin_lvl(pin_lvl));
  // compare one value and count it
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // register write, one strobe cycle
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // register read, data checked in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // let n edges pass, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle pulse on the monitor inputs
  task automatic pulse(input logic [8:0] p);
    @(posedge clk);
    cnd <= rmuv_pkg::rmuv_cond_t'(p);
    @(posedge clk);
    cnd <= '0;
    #1;
  endtask
  // bounded wait for a power state
  task automatic wait_st(input rmuv_pkg::rmuv_state_t exp);
    for (int i = 0; i < 8 && st !== exp; i++) @(posedge clk) #1;
    chk(16'(st), 16'(exp));
  endtask
  // finish a start-up sequence and reach ON
  task automatic restart();
    wait_st(rmuv_pkg::ST_START);
    chk(16'(sreq), 16'h0001);
    pulse(9'h001);
    wait_st(rmuv_pkg::ST_ON);
    chk(16'(pin_oe), 16'h0000);
  endtask
  // valid on event from OFF, then start-up
  task automatic go_on();
    pulse(9'h002);
    restart();
  endtask
  // defaults after reset, then first power-up
  task automatic t_init();
    wait_st(rmuv_pkg::ST_OFF);
    chk(16'(pin_oe), 16'h0001);
    rdc(16'h401B, 16'h03FF);
    rdc(16'h401C, 16'h000F);
    rdc(16'h4006, 16'h0400);
    rdc(16'h0000, 16'h0000);
    go_on();
  endtask
  // flag latching, masking and clearing
  task automatic t_flags();
    wr(16'h401B, 16'h0000);
    wr(16'h401C, 16'h0000);
    @(posedge clk);
    uv.ldo[9] <= 1'b1;
    uv.dc[0] <= 1'b1;
    tick(2);
    chk(16'(irq), 16'h0001);
    rdc(16'h4013, 16'h0200);
    rdc(16'h4014, 16'h0001);
    wr(16'h401B, 16'h0200);
    wr(16'h401C, 16'h0001);
    tick(2);
    chk(16'(irq), 16'h0000);
    rdc(16'h4013, 16'h0200);
    wr(16'h4013, 16'h0000);
    rdc(16'h4013, 16'h0200);
    wr(16'h4013, 16'h0200);
    wr(16'h4014, 16'h0001);
    rdc(16'h4013, 16'h0000);
    rdc(16'h4014, 16'h0000);
    @(posedge clk);
    uv <= '0;
  endtask
  // system reset causes and always-on supply low: no restart, map kept
  task automatic t_sys();
    logic [8:0] pats [5];
    pats = '{9'h020, 9'h008, 9'h010, 9'h040, 9'h080};
    wr(16'h4020, 16'h0001);
    pulse(9'h010);
    tick(2);
    chk(16'(st), 16'(rmuv_pkg::ST_ON));
    for (int i = 0; i < 5; i++) begin
      wr(16'h4020, 16'h0003);
      wr(16'h401B, 16'h0155);
      pulse(pats[i]);
      wait_st(i == 4 ? rmuv_pkg::ST_BACKUP : rmuv_pkg::ST_OFF);
      chk(16'(pin_oe), 16'h0001);
      rdc(16'h401B, 16'h0155);
      tick(4);
      chk(16'(sreq), 16'h0000);
      if (i < 4) begin
        go_on();
      end
    end
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    go_on();
  endtask
  // device reset causes, restart and retry limit
  task automatic t_dev();
    wr(16'h4020, 16'h0001);
    pulse(9'h004);
    tick(2);
    chk(16'(st), 16'(rmuv_pkg::ST_ON));
    wr(16'h401B, 16'h0000);
    wr(16'h4020, 16'h0005);
    pulse(9'h004);
    wait_st(rmuv_pkg::ST_OFF);
    rdc(16'h401B, 16'h03FF);
    restart();
    wr(16'h4022, 16'h0001);
    @(posedge clk);
    uv.dc[0] <= 1'b1;
    wait_st(rmuv_pkg::ST_OFF);
    @(posedge clk);
    uv.dc[0] <= 1'b0;
    rdc(16'h4014, 16'h0001);
    restart();
    tick(2);
    @(posedge clk);
    pull <= 1'b1;
    @(posedge clk);
    pull <= 1'b0;
    #1 chk(16'(st), 16'(rmuv_pkg::ST_OFF));
    restart();
    wr(16'h4020, 16'h0000);
    wait_st(rmuv_pkg::ST_OFF);
    tick(4);
    chk(16'(sreq), 16'h0000);
    go_on();
    for (int i = 0; i < 7; i++) begin
      wr(16'h4020, 16'h0005);
      pulse(9'h004);
      wait_st(rmuv_pkg::ST_OFF);
      if (i < 6) begin
        restart();
      end
    end
    tick(4);
    chk(16'(sreq), 16'h0000);
    rdc(16'h4023, 16'h0062);
  endtask
  // software reset with map kept and map cleared
  task automatic t_soft();
    go_on();
    wr(16'h401B, 16'h00AA);
    wr(16'h0000, 16'h1234);
    #1 chk(16'(st), 16'(rmuv_pkg::ST_OFF));
    chk(16'(pin_oe), 16'h0001);
    restart();
    rdc(16'h401B, 16'h00AA);
    wr(16'h4006, 16'h0000);
    wr(16'h0000, 16'h0000);
    #1 chk(16'(st), 16'(rmuv_pkg::ST_OFF));
    restart();
    rdc(16'h401B, 16'h03FF);
  endtask
  // power-on reset loses the map
  task automatic t_por();
    @(posedge clk);
    uv.ldo[0] <= 1'b1;
    tick(2);
    rdc(16'h4013, 16'h0001);
    @(posedge clk);
    uv <= '0;
    pulse(9'h100);
    chk(16'(st), 16'(rmuv_pkg::ST_NOPWR));
    wait_st(rmuv_pkg::ST_OFF);
    rdc(16'h4013, 16'h0000);
    tick(4);
    chk(16'(sreq), 16'h0000);
  endtask
  // counts and verdict, then end of run
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_init();
    t_flags();
    t_sys();
    t_dev();
    t_soft();
    t_por();
    stop_test();
  end
  // hang guard, far beyond the expected run of a few hundred cycles
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule // testbench
